/* File: parallel_port_mode_timing_map.vh */
// Register offsets, field positions and reset values of the parallel port.
// Assumes byte addresses on an APB bus with 32-bit data, one word per register.
`ifndef PARALLEL_PORT_MODE_TIMING_MAP_VH
`define PARALLEL_PORT_MODE_TIMING_MAP_VH
`define PP_MODE_OFS 8'h00
`define PP_CTRL_OFS 8'h04
`define PP_ADDR_OFS 8'h08
`define PP_WDATA_OFS 8'h0C
`define PP_CMD_OFS 8'h10
`define PP_RDATA_OFS 8'h14
`define PP_STAT_OFS 8'h18
`define PP_MASK_OFS 8'h1C
`define PP_OBUF_OFS 8'h20
`define PP_IBUF_OFS 8'h30
`define PP_BUSY_BIT 15
`define PP_IRQ_LSB 13
`define PP_STEP_LSB 11
`define PP_GAP_BIT 10
`define PP_MODE_LSB 8
`define PP_SETUP_LSB 6
`define PP_STROBE_LSB 2
`define PP_HOLD_LSB 0
`define PP_CTRL_EN_BIT 0
`define PP_CTRL_A14CS_BIT 1
`define PP_CMD_READ_BIT 0
`define PP_STAT_DONE_BIT 0
`define PP_STAT_BUF3_BIT 1
`define PP_MODE_RST 15'h0000
`define PP_CTRL_RST 2'h0
`define PP_ADDR_RST 15'h0000
`define PP_MASK_RST 2'h0
`define PP_MODE_LEGACY 2'h0
`define PP_MODE_ENH 2'h1
`define PP_MODE_MST2 2'h2
`define PP_MODE_MST1 2'h3
`define PP_STEP_NONE 2'h0
`define PP_STEP_INC 2'h1
`define PP_STEP_DEC 2'h2
`define PP_STEP_BUF 2'h3
`define PP_IRQ_NONE 2'h0
`define PP_IRQ_CYCLE 2'h1
`define PP_IRQ_BUF3 2'h2
`endif

/* File: parallel_port_mode_timing.v */
// Parallel port: APB registers, master cycle sequencer and slave buffers.
// Assumes all port pins are synchronous to clock; strobes and selects active high.
//
// Contract
// RULE_01: Step 01 adds one to address bits 10:2 and 14 per cycle.
// RULE_02: Step 10 subtracts one from address bits 10:2 and 14 per cycle.
// RULE_03: Step 00 leaves the address unchanged.
// RULE_04: Step 11 walks slave buffers, only in legacy slave mode.
// RULE_05: Address bit 14 used as select 1 is not stepped.
// RULE_06: Mode 11 master: select, direction line, enable strobe, address, data.
// RULE_07: Mode 10 master: select, separate read and write strobes, address, data.
// RULE_08: Mode 01 slave: external read, write, select, data, two address lines.
// RULE_09: Mode 00 slave: external read, write, select and data only.
// RULE_10: Setup field gives one to four clocks before the strobe.
// RULE_11: Strobe field gives field plus one clocks of strobe.
// RULE_12: Strobe field zero on write forces one setup and one hold clock.
// RULE_13: Strobe field zero on read forces one setup and no hold clock.
// RULE_14: Mode register bit 10 always reads zero.
// RULE_15: Busy bit reads one while a master cycle runs.
// RULE_16: Interrupt policy: none, each cycle end, buffer 3 or address 11.
// RULE_17: Software changes configuration only while idle and disabled.
`timescale 1ns/100ps
`include "parallel_port_mode_timing_map.vh"
`default_nettype none
module parallel_port_mode_timing (
   input wire clock,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg irq,
   output reg port_select_1,
   output reg port_read_strobe,
   output reg port_write_strobe,
   output reg port_enable_strobe,
   output reg [14:0] port_addr_lines,
   input wire [7:0] port_data_in,
   output reg [7:0] port_data_out,
   output reg port_data_oe,
   input wire slave_select_in,
   input wire slave_read_in,
   input wire slave_write_in,
   input wire [1:0] slave_addr_in
);
   localparam S_IDLE = 4'b0001;
   localparam S_SETUP = 4'b0010;
   localparam S_STROBE = 4'b0100;
   localparam S_HOLD = 4'b1000;

   reg [14:0] mode_q;
   reg [1:0] ctrl_q;
   reg [14:0] addr_q;
   reg [7:0] wdata_q;
   reg [7:0] rdata_q;
   reg [1:0] stat_q;
   reg [1:0] mask_q;
   reg [7:0] obuf_q [0:3];
   reg [7:0] ibuf_q [0:3];
   reg [1:0] rd_ptr_q;
   reg [1:0] wr_ptr_q;
   reg s_rd_p_q;
   reg s_wr_p_q;
   reg [3:0] st_q;
   reg [3:0] st_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg dir_rd_q;
   reg done;
   reg [31:0] rd_mux;
   reg map_hit;

   wire [1:0] irq_pol = mode_q[`PP_IRQ_LSB+1:`PP_IRQ_LSB];
   wire [1:0] step = mode_q[`PP_STEP_LSB+1:`PP_STEP_LSB];
   wire [1:0] mode = mode_q[`PP_MODE_LSB+1:`PP_MODE_LSB];
   wire [1:0] setup_wait_count = mode_q[`PP_SETUP_LSB+1:`PP_SETUP_LSB];
   wire [3:0] strobe_wait_count = mode_q[`PP_STROBE_LSB+3:`PP_STROBE_LSB];
   wire [1:0] hold_wait_count = mode_q[`PP_HOLD_LSB+1:`PP_HOLD_LSB];
   wire enabled = ctrl_q[`PP_CTRL_EN_BIT];
   wire a14_cs = ctrl_q[`PP_CTRL_A14CS_BIT];
   wire master = mode[1];
   wire idle = (st_q == S_IDLE);
   wire short_cyc = (strobe_wait_count == 4'h0);

   // APB access phase; answer comes one cycle into the access phase
   wire acc = psel & penable & pready;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   wire go_ok = enabled & master & idle;
   wire start_wr = go_ok & wr_acc & (paddr == `PP_WDATA_OFS);
   wire start_rd = go_ok & wr_acc & (paddr == `PP_CMD_OFS) & pwdata[`PP_CMD_READ_BIT];

   // Slave side access detection
   wire slave_on = enabled & ~master;
   wire s_rd = slave_select_in & slave_read_in;
   wire s_wr = slave_select_in & slave_write_in;
   wire rd_evt = slave_on & s_rd & ~s_rd_p_q;
   wire wr_evt = slave_on & s_wr & ~s_wr_p_q;
   wire buf_mode = (mode == `PP_MODE_LEGACY) & (step == `PP_STEP_BUF);
   wire [1:0] rd_idx = (mode == `PP_MODE_ENH) ? slave_addr_in :      // RULE_08
                       (buf_mode ? rd_ptr_q : 2'h0);                  // RULE_09
   wire [1:0] wr_idx = (mode == `PP_MODE_ENH) ? slave_addr_in :      // RULE_08
                       (buf_mode ? wr_ptr_q : 2'h0);                  // RULE_09
   wire buf3_evt = (rd_evt & (rd_idx == 2'h3)) | (wr_evt & (wr_idx == 2'h3));

   // Master cycle sequencer
   always @* begin
      st_d = st_q;
      cnt_d = cnt_q;
      done = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (start_wr | start_rd) begin
               st_d = S_SETUP;
               cnt_d = short_cyc ? 4'h0 : {2'b00, setup_wait_count};  // RULE_10 RULE_12 RULE_13
            end
         end
         S_SETUP: begin
            if (cnt_q == 4'h0) begin
               st_d = S_STROBE;
               cnt_d = strobe_wait_count;                              // RULE_11
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_STROBE: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (short_cyc) begin
               if (dir_rd_q) begin
                  st_d = S_IDLE;                                        // RULE_13
                  done = 1'b1;
               end else begin
                  st_d = S_HOLD;                                        // RULE_12
                  cnt_d = 4'h0;
               end
            end else if (hold_wait_count == 2'h0) begin
               st_d = S_IDLE;
               done = 1'b1;
            end else begin
               st_d = S_HOLD;
               cnt_d = {2'b00, hold_wait_count} - 4'h1;
            end
         end
         S_HOLD: begin
            if (cnt_q == 4'h0) begin
               st_d = S_IDLE;
               done = 1'b1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            st_d = S_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   // Address stepping after each completed master cycle
   wire [9:0] step_full = {addr_q[14], addr_q[10:2]};
   wire [9:0] full_inc = step_full + 10'h001;
   wire [9:0] full_dec = step_full - 10'h001;
   wire [8:0] low_inc = addr_q[10:2] + 9'h001;
   wire [8:0] low_dec = addr_q[10:2] - 9'h001;
   reg [14:0] addr_step;
   always @* begin
      addr_step = addr_q;
      if (step == `PP_STEP_INC) begin
         if (a14_cs) begin
            addr_step[10:2] = low_inc;                                  // RULE_05
         end else begin
            {addr_step[14], addr_step[10:2]} = full_inc;                // RULE_01
         end
      end else if (step == `PP_STEP_DEC) begin
         if (a14_cs) begin
            addr_step[10:2] = low_dec;                                  // RULE_05
         end else begin
            {addr_step[14], addr_step[10:2]} = full_dec;                // RULE_02
         end
      end
   end

   // Register read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      map_hit = 1'b1;
      case (paddr)
         `PP_MODE_OFS: begin
            rd_mux[14:0] = mode_q;
            rd_mux[`PP_GAP_BIT] = 1'b0;                                 // RULE_14
            rd_mux[`PP_BUSY_BIT] = master & ~idle;                      // RULE_15
         end
         `PP_CTRL_OFS: rd_mux[1:0] = ctrl_q;
         `PP_ADDR_OFS: rd_mux[14:0] = addr_q;
         `PP_WDATA_OFS: rd_mux[7:0] = wdata_q;
         `PP_CMD_OFS: rd_mux = 32'h0000_0000;
         `PP_RDATA_OFS: rd_mux[7:0] = rdata_q;
         `PP_STAT_OFS: rd_mux[1:0] = stat_q;
         `PP_MASK_OFS: rd_mux[1:0] = mask_q;
         `PP_OBUF_OFS, `PP_OBUF_OFS + 8'h04, `PP_OBUF_OFS + 8'h08, `PP_OBUF_OFS + 8'h0C: begin
            rd_mux[7:0] = obuf_q[paddr[3:2]];
         end
         `PP_IBUF_OFS, `PP_IBUF_OFS + 8'h04, `PP_IBUF_OFS + 8'h08, `PP_IBUF_OFS + 8'h0C: begin
            rd_mux[7:0] = ibuf_q[paddr[3:2]];
         end
         default: map_hit = 1'b0;
      endcase
   end

   // Events: cycle end (policy 01) and buffer 3 / address 11 (policy 10)
   wire ev_done = (irq_pol == `PP_IRQ_CYCLE) & (done | rd_evt | wr_evt);  // RULE_16
   wire ev_buf3 = (irq_pol == `PP_IRQ_BUF3) & buf3_evt;                   // RULE_16
   wire stat_clr = rd_acc & (paddr == `PP_STAT_OFS);
   wire [1:0] stat_d = (stat_clr ? 2'h0 : stat_q) | {ev_buf3, ev_done};

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         mode_q <= `PP_MODE_RST;
         ctrl_q <= `PP_CTRL_RST;
         addr_q <= `PP_ADDR_RST;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
         stat_q <= 2'h0;
         mask_q <= `PP_MASK_RST;
         irq <= 1'b0;
         rd_ptr_q <= 2'h0;
         wr_ptr_q <= 2'h0;
         s_rd_p_q <= 1'b0;
         s_wr_p_q <= 1'b0;
         st_q <= S_IDLE;
         cnt_q <= 4'h0;
         dir_rd_q <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~map_hit;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= rd_mux;
         end
         if (wr_acc) begin
            case (paddr)
               `PP_MODE_OFS: mode_q <= pwdata[14:0] & 15'h7BFF;         // RULE_14
               `PP_CTRL_OFS: ctrl_q <= pwdata[1:0];
               `PP_WDATA_OFS: wdata_q <= pwdata[7:0];
               `PP_MASK_OFS: mask_q <= pwdata[1:0];
               default: ;
            endcase
         end
         if (wr_acc & (paddr == `PP_ADDR_OFS)) begin
            addr_q <= pwdata[14:0];
         end else if (done) begin
            addr_q <= addr_step;                                        // RULE_03
         end
         if (st_q == S_IDLE) begin
            dir_rd_q <= start_rd;
         end
         if ((st_q == S_STROBE) & (st_d != S_STROBE) & dir_rd_q) begin
            rdata_q <= port_data_in;
         end
         st_q <= st_d;
         cnt_q <= cnt_d;
         stat_q <= stat_d;
         irq <= |(stat_d & mask_q);
         s_rd_p_q <= s_rd;
         s_wr_p_q <= s_wr;
         if (rd_evt & buf_mode) begin
            rd_ptr_q <= rd_ptr_q + 2'h1;                                // RULE_04
         end
         if (wr_evt & buf_mode) begin
            wr_ptr_q <= wr_ptr_q + 2'h1;                                // RULE_04
         end
      end
   end

   // Slave buffers: software fills output side, external master fills input side
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_buf
         always @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               obuf_q[gi] <= 8'h00;
               ibuf_q[gi] <= 8'h00;
            end else begin
               if (wr_acc & (paddr == (`PP_OBUF_OFS + 4 * gi))) begin
                  obuf_q[gi] <= pwdata[7:0];
               end
               if (wr_evt & (wr_idx == gi)) begin
                  ibuf_q[gi] <= port_data_in;                           // RULE_08 RULE_09
               end
            end
         end
      end
   endgenerate

   // Pin drivers, registered from the next sequencer state
   wire act_d = master & (st_d != S_IDLE);
   wire strobe_d = master & (st_d == S_STROBE);
   wire rd_dir_d = (st_q == S_IDLE) ? start_rd : dir_rd_q;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         port_select_1 <= 1'b0;
         port_read_strobe <= 1'b0;
         port_write_strobe <= 1'b0;
         port_enable_strobe <= 1'b0;
         port_addr_lines <= 15'h0000;
         port_data_out <= 8'h00;
         port_data_oe <= 1'b0;
      end else begin
         port_select_1 <= act_d;
         port_addr_lines <= addr_q;
         if (a14_cs) begin
            port_addr_lines[14] <= act_d;                               // RULE_05
         end
         if (mode == `PP_MODE_MST1) begin
            port_read_strobe <= act_d & rd_dir_d;                       // RULE_06
            port_write_strobe <= 1'b0;
            port_enable_strobe <= strobe_d;                             // RULE_06
         end else begin
            port_read_strobe <= strobe_d & rd_dir_d;                    // RULE_07
            port_write_strobe <= strobe_d & ~rd_dir_d;                  // RULE_07
            port_enable_strobe <= 1'b0;
         end
         if (master) begin
            port_data_out <= start_wr ? pwdata[7:0] : wdata_q;           // RULE_10
            port_data_oe <= act_d & ~rd_dir_d;
         end else begin
            if (rd_evt) begin
               port_data_out <= obuf_q[rd_idx];                         // RULE_08 RULE_09
            end
            port_data_oe <= slave_on & s_rd;
         end
      end
   end
endmodule // parallel_port_mode_timing
`default_nettype wire

/* File: parallel_port_mode_timing_asserts.sv */
// Checker for the APB answer and the master-cycle pins of the parallel port.
// Bound into parallel_port_mode_timing; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module parallel_port_mode_timing_asserts (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic port_select_1,
   input wire logic port_write_strobe,
   input wire logic port_enable_strobe,
   input wire logic [14:0] port_addr_lines
);
   int sel_cnt;
   wire logic stb = port_write_strobe || port_enable_strobe;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) sel_cnt <= 0;
      else sel_cnt <= port_select_1 ? sel_cnt + 1 : 0;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   ready_second_a: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not in second access cycle");
   ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready not a single access pulse");
   err_map_a: assert property (pready |-> pslverr == (paddr >= 8'h40 || paddr[1:0] != 2'h0))
      else $error("pslverr does not match the map");
   gap_bit_a: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[10])
      else $error("mode bit 10 read as one");
   setup_first_a: assert property ($rose(port_select_1) |-> !stb)
      else $error("strobe without setup cycle");
   strobe_inside_a: assert property (stb |-> port_select_1)
      else $error("strobe outside select");
   strobe_excl_a: assert property (port_enable_strobe |-> !port_write_strobe)
      else $error("enable and write strobe together");
   hold_bound_a: assert property ($fell(stb) |-> ##[0:3] !port_select_1)
      else $error("hold phase too long");
   cycle_bound_a: assert property (sel_cnt <= 23)
      else $error("master cycle too long");
   addr_hold_a: assert property (
      port_select_1 && $past(port_select_1) |-> $stable(port_addr_lines))
      else $error("address moved inside a cycle");
   cover property ($fell(port_select_1));
   cover property (pready && pslverr);
   cover property (port_enable_strobe);
endmodule // parallel_port_mode_timing_asserts
bind parallel_port_mode_timing parallel_port_mode_timing_asserts u_parallel_port_mode_timing_asserts
   (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .port_select_1,
   .port_write_strobe, .port_enable_strobe, .port_addr_lines);
`default_nettype wire

/* File: port_peripheral.sv */
// Peripheral on the port pins: answers master reads, carries bench bytes as external master.
// Pins are synchronous to clock; an undriven data line shows a changing pattern.
`timescale 1ns/100ps
`default_nettype none
module port_peripheral (
   input wire logic clock,
   input wire logic port_select_1,
   input wire logic port_read_strobe,
   input wire logic port_data_oe,
   input wire logic [14:0] port_addr_lines,
   input wire logic ext_en,
   input wire logic [7:0] ext_byte,
   output logic [7:0] port_data_in
);
   logic [7:0] last_q = 8'h00;
   wire logic rd_w = port_select_1 && port_read_strobe && !port_data_oe;
   always @(posedge clock) begin
      last_q <= port_data_in;
   end
   always_comb begin
      if (ext_en) port_data_in = ext_byte;
      else if (rd_w) port_data_in = port_addr_lines[9:2] ^ 8'hA5;
      else port_data_in = ~last_q;
   end
endmodule // port_peripheral
`default_nettype wire

/* File: tb_parallel_port_mode_timing.sv */
// Bench for the parallel port: APB tasks, master cycles, slave accesses.
// Needs the design, its map header, the peripheral model and the checker.
`timescale 1ns/100ps
`include "parallel_port_mode_timing_map.vh"
`default_nettype none
module tb_parallel_port_mode_timing;
   logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, ext_en = 0, e;
   logic slave_select_in = 0, slave_read_in = 0, slave_write_in = 0;
   logic [1:0] slave_addr_in = 2'h0;
   logic [7:0] paddr = 8'h00, ext_byte = 8'h00;
   logic [31:0] pwdata = 32'h0, r;
   wire [31:0] prdata;
   wire [14:0] port_addr_lines;
   wire [7:0] port_data_in, port_data_out;
   wire pready, pslverr, irq, port_select_1, port_read_strobe, port_write_strobe;
   wire port_enable_strobe, port_data_oe;
   int bad_count = 0, check_count = 0, sel_n, stb_n, rd_n, dat_n;
   logic [14:0] adr_c = 15'h0000;
   parallel_port_mode_timing u_parallel_port_mode_timing (.clock, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .port_select_1,
      .port_read_strobe, .port_write_strobe, .port_enable_strobe, .port_addr_lines,
      .port_data_in, .port_data_out, .port_data_oe, .slave_select_in, .slave_read_in,
      .slave_write_in, .slave_addr_in);
   port_peripheral u_port_peripheral (.clock, .port_select_1, .port_read_strobe, .port_data_oe,
      .port_addr_lines, .ext_en, .ext_byte, .port_data_in);
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (port_select_1) sel_n <= sel_n + 1;
      if (port_write_strobe || port_enable_strobe) stb_n <= stb_n + 1;
      if (port_read_strobe && port_select_1) rd_n <= rd_n + 1;
      if (port_select_1 && port_data_oe && port_data_out == 8'hC3) dat_n <= dat_n + 1;
      if (port_select_1) adr_c <= port_addr_lines;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(r, x);
   endtask
   function automatic logic [31:0] mk(input logic [1:0] q, st, md, su, input logic [3:0] sw,
      input logic [1:0] ho);
      return {17'h0, q, st, 1'b0, md, su, sw, ho};
   endfunction
   task automatic mrun(input logic [31:0] m, input logic rdop, input logic [1:0] c,
      input logic [14:0] a, input logic [14:0] ea, input logic [1:0] ep, input logic ei);
      int s, w, h, n;
      logic [31:0] b;
      s = (m[5:2] == 4'h0) ? 1 : m[7:6] + 1;
      w = m[5:2] + 1;
      h = (m[5:2] != 4'h0) ? m[1:0] : (rdop ? 0 : 1);
      n = 0;
      wr(`PP_CTRL_OFS, 32'h0);
      wr(`PP_MODE_OFS, m);
      wr(`PP_ADDR_OFS, {17'h0, a});
      wr(`PP_CTRL_OFS, {30'h0, c});
      sel_n = 0;
      stb_n = 0;
      rd_n = 0;
      dat_n = 0;
      if (rdop) wr(`PP_CMD_OFS, 32'h1);
      else wr(`PP_WDATA_OFS, 32'hC3);
      do begin
         apb(1'b0, `PP_MODE_OFS, 32'h0);
         if (n == 0) b = r;
         n++;
      end while (r[`PP_BUSY_BIT] !== 1'b0 && n < 20);
      check(r[`PP_BUSY_BIT], 1'b0);
      if (s + w + h > 6) check(b[`PP_BUSY_BIT], 1'b1);
      check(dat_n, rdop ? 0 : s + w + h);
      check(adr_c, c[1] ? {1'b1, a[13:0]} : a);
      check(sel_n, s + w + h);
      check(stb_n, (m[9:8] == `PP_MODE_MST1 || !rdop) ? w : 0);
      check(rd_n, !rdop ? 0 : (m[9:8] == `PP_MODE_MST1) ? s + w + h : w);
      rd(`PP_ADDR_OFS, {17'h0, ea});
      if (rdop) rd(`PP_RDATA_OFS, {24'h0, a[9:2] ^ 8'hA5});
      check(irq, ei);
      rd(`PP_STAT_OFS, {30'h0, ep});
      rd(`PP_STAT_OFS, 32'h0);
      check(irq, 1'b0);
      $display("master test finished");
   endtask
   task automatic ext(input logic rdx, input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      slave_select_in <= 1'b1;
      slave_read_in <= rdx;
      slave_write_in <= !rdx;
      slave_addr_in <= a;
      ext_en <= !rdx;
      ext_byte <= d;
      repeat (3) @(posedge clock);
      if (rdx) check({port_data_oe, port_data_out}, {1'b1, d});
      slave_select_in <= 1'b0;
      slave_read_in <= 1'b0;
      slave_write_in <= 1'b0;
      ext_en <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      rd(`PP_MODE_OFS, 32'h0);
      rd(`PP_CTRL_OFS, 32'h0);
      rd(`PP_MASK_OFS, 32'h0);
      wr(`PP_MODE_OFS, 32'hFFFFFFFF);
      rd(`PP_MODE_OFS, 32'h00007BFF);
      apb(1'b0, 8'h40, 32'h0);
      check({e, r[30:0]}, 32'h80000000);
      $display("register test finished");
      wr(`PP_MASK_OFS, 32'h1);
      mrun(mk(2'h1, 2'h1, 2'h2, 2'h0, 4'h0, 2'h2), 1'b0, 2'h1, 15'h0004, 15'h0008, 2'h1, 1'b1);
      mrun(mk(2'h0, 2'h2, 2'h3, 2'h3, 4'h2, 2'h1), 1'b1, 2'h1, 15'h0008, 15'h0004, 2'h0, 1'b0);
      mrun(mk(2'h3, 2'h0, 2'h2, 2'h2, 4'h0, 2'h3), 1'b1, 2'h1, 15'h0010, 15'h0010, 2'h0, 1'b0);
      mrun(mk(2'h1, 2'h1, 2'h3, 2'h1, 4'hF, 2'h3), 1'b0, 2'h1, 15'h47FC, 15'h0000, 2'h1, 1'b1);
      wr(`PP_MASK_OFS, 32'h0);
      mrun(mk(2'h1, 2'h1, 2'h2, 2'h0, 4'h1, 2'h0), 1'b0, 2'h3, 15'h47FC, 15'h4000, 2'h1, 1'b0);
      wr(`PP_CTRL_OFS, 32'h0);
      wr(`PP_MODE_OFS, mk(2'h0, 2'h3, 2'h0, 2'h0, 4'h0, 2'h0));
      wr(`PP_CTRL_OFS, 32'h1);
      for (int i = 0; i < 4; i++) ext(1'b0, 2'h0, 8'(8'h10 + i));
      for (int i = 0; i < 4; i++) rd(8'(`PP_IBUF_OFS + 4 * i), 32'h10 + i);
      rd(`PP_MODE_OFS, 32'h00001800);
      $display("legacy slave test finished");
      wr(`PP_CTRL_OFS, 32'h0);
      wr(`PP_MODE_OFS, mk(2'h2, 2'h0, 2'h1, 2'h0, 4'h0, 2'h0));
      wr(`PP_MASK_OFS, 32'h3);
      wr(`PP_CTRL_OFS, 32'h1);
      wr(`PP_OBUF_OFS + 8'h08, 32'h3C);
      ext(1'b1, 2'h2, 8'h3C);
      rd(`PP_STAT_OFS, 32'h0);
      ext(1'b0, 2'h3, 8'h77);
      check(irq, 1'b1);
      rd(`PP_IBUF_OFS + 8'h0C, 32'h77);
      rd(`PP_STAT_OFS, 32'h2);
      $display("enhanced slave test finished");
      wrap_up;
   end
endmodule // tb_parallel_port_mode_timing
`default_nettype wire
